// *** common/sar_seq_defs.svh ***
// Purpose: Offsets, fields, channel codes and timing of the converter sequencer
// Assumes: 10 MHz ref_clk
`ifndef SAR_SEQ_DEFS_SVH
`define SAR_SEQ_DEFS_SVH

`define REG_CTRL 8'h26
`define REG_RES_HI 8'h27
`define REG_RES_LO 8'h28
`define REG_AUD_CTRL 8'h46
`define REG_AUD_OUT 8'h48

`define CTRL_START_BIT 7
`define CTRL_SEL_MSB 5
`define RES_BUSY_BIT 7
`define AUD_BUF_ON_BIT 0
`define AUD_COLOR_MSB 4
`define AUD_COLOR_LSB 2
`define AUD_LV_SYNC_BIT 3
`define AUD_HV_SYNC_BIT 4

`define CH_LV_SINK_THREE 6'h0c
`define CH_LV_SINK_FOUR 6'h0d
`define CH_HV_SINK_THREE 6'h13
`define CH_PUMP_OUT 6'h15
`define CH_STEPUP_FB 6'h16
`define CH_JUNCTION_TEMP 6'h17

`define CLK_HZ 10000000
`define CONV_CLK_HZ 1000000
`define SETTLE_US 16
`define CONV_TIME_US 27
`define AUDIO_RATE_HZ 45500
`define AUDIO_SETTLE_TICKS 1
`define SAR_MID 10'h200
`define LED_FULL 8'hff

`endif

// *** common/sar_seq_pkg.sv ***
// Purpose: Types shared by the converter sequencer
// Assumes: nothing
// Notes: sample width fixed by the converter
package sar_seq_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_BITS, ST_DONE} sar_state_e;
	typedef logic [9:0] sample_t;
endpackage

// *** common/sample_stream_if.sv ***
// Purpose: Valid/ready stream of converter samples
// Assumes: one clock
// Notes: data stands while valid and not ready
`timescale 1ns/100ps
`default_nettype none
interface sample_stream_if #(parameter int W = 10) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** src/sample_fifo.sv ***
// Purpose: Sample FIFO with registered output stage
// Assumes: DEPTH a power of two
// Notes: in.ready drops when full
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	sample_stream_if.snk in_s,
	sample_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic ov_r, ov_nxt;
	logic [WIDTH-1:0] od_r, od_nxt;
	logic push, load;

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH != $bits(in_s.data))
		$error("sample_fifo: bad DEPTH or WIDTH");

	assign in_s.ready = cnt_r != (AW+1)'(DEPTH);
	assign out_s.valid = ov_r;
	assign out_s.data = od_r;

	always_comb begin
		push = in_s.valid && in_s.ready;
		load = (cnt_r != '0) && (!ov_r || out_s.ready);
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = load ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
		ov_nxt = load ? 1'b1 : (out_s.ready ? 1'b0 : ov_r);
		od_nxt = load ? mem[rp_r] : od_r;
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_r] <= in_s.data;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			ov_r <= 1'b0;
			od_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			ov_r <= ov_nxt;
			od_r <= od_nxt;
		end
	end
endmodule // sample_fifo
`default_nettype wire

// *** src/audio_colour_map.sv ***
// Purpose: Maps audio sample amplitude to colour and brightness
// Assumes: samples centred on mid-scale
// Notes: outputs registered, held until led_ready
`timescale 1ns/100ps
`default_nettype none
`include "sar_seq_defs.svh"
module audio_colour_map
	import sar_seq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	sample_stream_if.snk smp_s,
	input wire logic [2:0] colour_sel,
	input wire logic lv_sync,
	input wire logic hv_sync,
	input wire logic led_ready,
	output logic led_valid,
	output logic [7:0] led_level,
	output logic [2:0] lv_rgb_en,
	output logic [2:0] hv_rgb_en
);
	logic v_r, v_nxt;
	logic [7:0] lvl_r, lvl_nxt;
	logic [2:0] lv_r, lv_nxt, hv_r, hv_nxt;
	sample_t amp;
	logic [7:0] bright;
	logic [2:0] rgb;

	assign smp_s.ready = !v_r || led_ready;
	assign led_valid = v_r;
	assign led_level = lvl_r;
	assign lv_rgb_en = lv_r;
	assign hv_rgb_en = hv_r;

	always_comb begin
		amp = (smp_s.data >= `SAR_MID) ? smp_s.data - `SAR_MID : `SAR_MID - smp_s.data;
		bright = amp[9] ? `LED_FULL : amp[8:1];
		rgb = colour_sel;
		if (colour_sel == 3'h0) begin
			case (bright[7:5])
				3'h0: rgb = 3'h0;
				3'h1: rgb = 3'h1;
				3'h2: rgb = 3'h2;
				3'h3: rgb = 3'h3;
				3'h4: rgb = 3'h6;
				3'h5: rgb = 3'h4;
				default: rgb = 3'h7;
			endcase
		end
		v_nxt = v_r;
		lvl_nxt = lvl_r;
		lv_nxt = lv_r;
		hv_nxt = hv_r;
		if (smp_s.valid && smp_s.ready) begin
			v_nxt = 1'b1;
			lvl_nxt = (colour_sel == 3'h0) ? `LED_FULL : bright;
			lv_nxt = lv_sync ? rgb : 3'h0;
			hv_nxt = hv_sync ? rgb : 3'h0;
		end else if (led_ready) begin
			v_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			v_r <= 1'b0;
			lvl_r <= '0;
			lv_r <= '0;
			hv_r <= '0;
		end else begin
			v_r <= v_nxt;
			lvl_r <= lvl_nxt;
			lv_r <= lv_nxt;
			hv_r <= hv_nxt;
		end
	end
endmodule // audio_colour_map
`default_nettype wire

// *** src/sar_converter_sequencer.sv ***
// Purpose: Successive-approximation sequencer with registers and audio mode
// Assumes: 10 MHz ref_clk, comparator high when input at or above DAC
// Notes: audio samples flow through a FIFO to the colour mapper
`timescale 1ns/100ps
`default_nettype none
`include "sar_seq_defs.svh"
module sar_converter_sequencer
	import sar_seq_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic cmp_in,
	output logic [9:0] dac_code,
	output logic [5:0] mux_code,
	output logic prescale_en,
	output logic temp_sense_en,
	output logic sample_hold,
	output logic conv_active,
	output logic audio_amp_en,
	input wire logic led_ready,
	output logic led_valid,
	output logic [7:0] led_level,
	output logic [2:0] lv_rgb_en,
	output logic [2:0] hv_rgb_en
);
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int DIV = `CLK_HZ / `CONV_CLK_HZ;
	localparam logic [4:0] SETTLE_TICKS = 5'(`SETTLE_US * (`CONV_CLK_HZ / 1000000));
	localparam logic [4:0] CONV_TICKS = 5'(`CONV_TIME_US * (`CONV_CLK_HZ / 1000000));
	localparam logic [4:0] AUD_SETTLE = 5'(`AUDIO_SETTLE_TICKS);
	localparam int AUD_PER = `CLK_HZ / `AUDIO_RATE_HZ;
	localparam logic [3:0] DIV_LAST = 4'(DIV - 1);
	localparam logic [7:0] AUD_LAST = 8'(AUD_PER - 1);

	if (DIV < 2 || DIV > 16 || AUD_PER > 256 || AUD_PER < 13 * DIV)
		$error("sar_converter_sequencer: clock ratios out of range");
	if (CONV_TICKS != SETTLE_TICKS + 5'd11)
		$error("sar_converter_sequencer: conversion time mismatch");

	sample_stream_if #(.W(10)) push_s ();
	sample_stream_if #(.W(10)) map_s ();

	logic [3:0] div_r, div_nxt;
	logic [7:0] aud_r, aud_nxt;
	logic tick, aud_tick;
	logic cmp_meta_r, cmp_sync_r;
	logic [5:0] sel_r, sel_nxt;
	logic buf_on_r, buf_on_nxt;
	logic [2:0] colour_r, colour_nxt;
	logic lv_sync_r, lv_sync_nxt, hv_sync_r, hv_sync_nxt;
	logic busy_r, busy_nxt;
	sample_t result_r, result_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	sar_state_e st_r, st_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [3:0] bit_r, bit_nxt;
	sample_t trial_r, trial_nxt;
	logic aud_conv_r, aud_conv_nxt;
	logic aud_pend_r, aud_pend_nxt;
	logic [5:0] mux_r, mux_nxt;
	logic push_r, push_nxt;
	sample_t push_d_r, push_d_nxt;
	logic audio_mode, sw_start, aud_start, ctrl_wr;

	// ----------------------------------------
	// Clock enables and comparator sync
	// ----------------------------------------
	always_comb begin
		tick = div_r == DIV_LAST;
		div_nxt = tick ? 4'h0 : div_r + 4'h1;
		aud_tick = aud_r == AUD_LAST;
		aud_nxt = aud_tick ? 8'h0 : aud_r + 8'h1;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= '0;
			aud_r <= '0;
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			aud_r <= aud_nxt;
			cmp_meta_r <= cmp_in;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_comb begin
		audio_mode = lv_sync_r || hv_sync_r;
		ctrl_wr = reg_wr && reg_addr == `REG_CTRL;
		// Trigger ignored while busy or in audio mode
		sw_start = ctrl_wr && reg_wdata[`CTRL_START_BIT] && !busy_r && !audio_mode;
		sel_nxt = sel_r;
		buf_on_nxt = buf_on_r;
		colour_nxt = colour_r;
		lv_sync_nxt = lv_sync_r;
		hv_sync_nxt = hv_sync_r;
		if (ctrl_wr) begin
			sel_nxt = reg_wdata[`CTRL_SEL_MSB:0];
		end
		if (reg_wr && reg_addr == `REG_AUD_CTRL) begin
			buf_on_nxt = reg_wdata[`AUD_BUF_ON_BIT];
			colour_nxt = reg_wdata[`AUD_COLOR_MSB:`AUD_COLOR_LSB];
		end
		if (reg_wr && reg_addr == `REG_AUD_OUT) begin
			lv_sync_nxt = reg_wdata[`AUD_LV_SYNC_BIT];
			hv_sync_nxt = reg_wdata[`AUD_HV_SYNC_BIT];
		end
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL: rdata_nxt = {2'b00, sel_r};
				`REG_RES_HI: rdata_nxt = {busy_r, result_r[9:3]};
				`REG_RES_LO: rdata_nxt = {5'h00, result_r[2:0]};
				`REG_AUD_CTRL: rdata_nxt = {3'h0, colour_r, 1'b0, buf_on_r};
				`REG_AUD_OUT: rdata_nxt = {3'h0, hv_sync_r, lv_sync_r, 3'h0};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sel_r <= '0;
			buf_on_r <= 1'b0;
			colour_r <= '0;
			lv_sync_r <= 1'b0;
			hv_sync_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			sel_r <= sel_nxt;
			buf_on_r <= buf_on_nxt;
			colour_r <= colour_nxt;
			lv_sync_r <= lv_sync_nxt;
			hv_sync_r <= hv_sync_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	always_comb begin
		// Next audio sample waits for FIFO room
		aud_start = st_r == ST_IDLE && aud_pend_r && audio_mode && push_s.ready && !push_r;
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		trial_nxt = trial_r;
		aud_conv_nxt = aud_conv_r;
		mux_nxt = mux_r;
		busy_nxt = busy_r;
		result_nxt = result_r;
		push_nxt = push_r && !push_s.ready;
		push_d_nxt = push_d_r;
		aud_pend_nxt = (aud_pend_r || (aud_tick && audio_mode)) && !aud_start;
		case (st_r)
			ST_IDLE: begin
				if (sw_start) begin
					st_nxt = ST_SETTLE;
					cnt_nxt = 5'h0;
					aud_conv_nxt = 1'b0;
					mux_nxt = sel_nxt;
					busy_nxt = 1'b1;
				end else if (aud_start) begin
					st_nxt = ST_SETTLE;
					cnt_nxt = 5'h0;
					aud_conv_nxt = 1'b1;
					mux_nxt = `CH_LV_SINK_FOUR;
				end
			end
			ST_SETTLE: begin
				if (tick) begin
					if (cnt_r == (aud_conv_r ? AUD_SETTLE : SETTLE_TICKS) - 5'h1) begin
						st_nxt = ST_BITS;
						bit_nxt = 4'h9;
						trial_nxt = `SAR_MID;
					end else begin
						cnt_nxt = cnt_r + 5'h1;
					end
				end
			end
			ST_BITS: begin
				if (tick) begin
					trial_nxt[bit_r] = cmp_sync_r;
					if (bit_r == 4'h0) begin
						st_nxt = ST_DONE;
					end else begin
						bit_nxt = bit_r - 4'h1;
						trial_nxt[bit_r - 4'h1] = 1'b1;
					end
				end
			end
			ST_DONE: begin
				if (tick) begin
					st_nxt = ST_IDLE;
					if (aud_conv_r) begin
						push_nxt = 1'b1;
						push_d_nxt = trial_r;
					end else begin
						result_nxt = trial_r;
						busy_nxt = 1'b0;
					end
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= ST_IDLE;
			cnt_r <= '0;
			bit_r <= '0;
			trial_r <= '0;
			aud_conv_r <= 1'b0;
			aud_pend_r <= 1'b0;
			mux_r <= '0;
			busy_r <= 1'b0;
			result_r <= '0;
			push_r <= 1'b0;
			push_d_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			trial_r <= trial_nxt;
			aud_conv_r <= aud_conv_nxt;
			aud_pend_r <= aud_pend_nxt;
			mux_r <= mux_nxt;
			busy_r <= busy_nxt;
			result_r <= result_nxt;
			push_r <= push_nxt;
			push_d_r <= push_d_nxt;
		end
	end

	// ----------------------------------------
	// Audio path
	// ----------------------------------------
	assign push_s.valid = push_r;
	assign push_s.data = push_d_r;

	sample_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_s(push_s),
		.out_s(map_s)
	);

	audio_colour_map u_map (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.smp_s(map_s),
		.colour_sel(colour_r),
		.lv_sync(lv_sync_r),
		.hv_sync(hv_sync_r),
		.led_ready(led_ready),
		.led_valid(led_valid),
		.led_level(led_level),
		.lv_rgb_en(lv_rgb_en),
		.hv_rgb_en(hv_rgb_en)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = rdata_r;
	assign dac_code = trial_r;
	assign mux_code = mux_r;
	assign prescale_en = mux_r == `CH_LV_SINK_THREE || mux_r == `CH_LV_SINK_FOUR
		|| mux_r == `CH_PUMP_OUT;
	assign temp_sense_en = mux_r == `CH_JUNCTION_TEMP;
	assign sample_hold = st_r == ST_SETTLE;
	assign conv_active = st_r != ST_IDLE;
	assign audio_amp_en = buf_on_r;
endmodule // sar_converter_sequencer
`default_nettype wire

// *** bench/sar_converter_sequencer_assertions.sv ***
// Purpose: Port checker for the converter sequencer
// Assumes: 10 MHz ref_clk
// Notes: helper counters time settle and conversion
`timescale 1ns/100ps
`default_nettype none
module sar_converter_sequencer_assertions #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [5:0] mux_code,
	input wire logic prescale_en,
	input wire logic temp_sense_en,
	input wire logic sample_hold,
	input wire logic conv_active,
	input wire logic audio_amp_en,
	input wire logic led_ready,
	input wire logic led_valid,
	input wire logic [7:0] led_level
);
	// --
	// Helper state
	// --
	logic aud_r, aud_nxt, sw_r, sw_nxt, start_w;
	logic [8:0] hold_r, hold_nxt, act_r, act_nxt;
	assign start_w = reg_wr && reg_addr == 8'h26 && reg_wdata[7] && !conv_active && !aud_r;
	always_comb begin
		aud_nxt = aud_r;
		if (reg_wr && reg_addr == 8'h48)
			aud_nxt = reg_wdata[3] | reg_wdata[4];
		sw_nxt = start_w ? 1'b1 : (conv_active ? sw_r : 1'b0);
		hold_nxt = sample_hold ? hold_r + 9'h1 : 9'h0;
		act_nxt = conv_active ? act_r + 9'h1 : 9'h0;
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			aud_r <= 1'b0;
			sw_r <= 1'b0;
			hold_r <= 9'h0;
			act_r <= 9'h0;
		end else begin
			aud_r <= aud_nxt;
			sw_r <= sw_nxt;
			hold_r <= hold_nxt;
			act_r <= act_nxt;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// --
	// Properties
	// --
	AST_START: assert property (
		start_w |=> conv_active && sample_hold && mux_code == $past(reg_wdata[5:0]))
		else $error("start write did not launch a conversion");
	AST_SETTLE: assert property (
		$fell(sample_hold) && sw_r |-> hold_r >= 9'd150 && hold_r <= 9'd161)
		else $error("settle length off");
	AST_CONV_TIME: assert property (
		$fell(conv_active) && sw_r |-> act_r >= 9'd258 && act_r <= 9'd271)
		else $error("conversion length off");
	AST_DECODE: assert property (
		prescale_en == (mux_code inside {6'h0c, 6'h0d, 6'h15})
		&& temp_sense_en == (mux_code == 6'h17))
		else $error("channel decode wrong");
	AST_BUSY_READ: assert property (
		reg_rd && reg_addr == 8'h27 && (sw_r || !conv_active)
		|=> reg_rdata[7] == $past(conv_active))
		else $error("busy bit wrong");
	AST_CTRL_READ: assert property (
		reg_rd && reg_addr == 8'h26 |=> reg_rdata[7:6] == 2'b00)
		else $error("control upper bits not zero");
	AST_AMP: assert property (
		reg_wr && reg_addr == 8'h46 |=> audio_amp_en == $past(reg_wdata[0]))
		else $error("amplifier enable wrong");
	AST_LED_HOLD: assert property (
		led_valid && !led_ready |=> led_valid && $stable(led_level))
		else $error("led output dropped while stalled");
	AST_AUDIO_MUX: assert property (
		$rose(conv_active) && aud_r |-> mux_code == 6'h0d)
		else $error("audio conversion on wrong channel");
	cover property (start_w);
	cover property ($rose(conv_active) && aud_r);
	cover property (led_valid && !led_ready ##1 led_valid);
endmodule // sar_converter_sequencer_assertions
`default_nettype wire

// *** bench/analog_front_model.sv ***
// Purpose: Analog mux, hold capacitor and comparator
// Assumes: each channel rests at a level set by its code
// Notes: level captured while sample_hold is high
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
	input wire logic ref_clk,
	input wire logic [5:0] mux_code,
	input wire logic sample_hold,
	input wire logic [9:0] dac_code,
	output logic cmp_in
);
	logic [9:0] held_r = 10'h0;
	always_ff @(posedge ref_clk) begin
		if (sample_hold) begin
			held_r <= {mux_code, 4'h5};
		end
	end
	assign cmp_in = held_r >= dac_code;
endmodule // analog_front_model
`default_nettype wire

// *** bench/tb_sar_converter_sequencer.sv ***
// Purpose: Self-checking bench for the converter sequencer
// Assumes: inputs change on the falling edge
// Notes: channel levels come from the analog front model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_sar_converter_sequencer;
	typedef struct packed {logic [5:0] sel; logic pre; logic tmp;} row_s;
	row_s rows [6] = '{'{6'h0c, 1'b1, 1'b0}, '{6'h0d, 1'b1, 1'b0}, '{6'h13, 1'b0, 1'b0},
		'{6'h15, 1'b1, 1'b0}, '{6'h16, 1'b0, 1'b0}, '{6'h17, 1'b0, 1'b1}};
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata, led_level, rd;
	logic reg_wr = 1'b0, reg_rd = 1'b0, led_ready = 1'b0, cmp_in, prescale_en, temp_sense_en;
	logic sample_hold, conv_active, audio_amp_en, led_valid;
	logic [9:0] dac_code;
	logic [5:0] mux_code;
	logic [2:0] lv_rgb_en, hv_rgb_en;
	int fails = 0, compares = 0, cycles = 0, n;
	sar_converter_sequencer #(.FIFO_DEPTH(16)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .cmp_in(cmp_in), .dac_code(dac_code), .mux_code(mux_code),
		.prescale_en(prescale_en), .temp_sense_en(temp_sense_en), .sample_hold(sample_hold),
		.conv_active(conv_active), .audio_amp_en(audio_amp_en), .led_ready(led_ready),
		.led_valid(led_valid), .led_level(led_level), .lv_rgb_en(lv_rgb_en),
		.hv_rgb_en(hv_rgb_en));
	analog_front_model i_front (.ref_clk(ref_clk), .mux_code(mux_code),
		.sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in));
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			close_out();
		end
	end
	task automatic close_out();
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		rd = reg_rdata;
	endtask
	task automatic wait_res(input logic [9:0] v);
		rd = 8'hff;
		for (n = 0; n < 200 && rd[7] !== 1'b0; n++) rdr(8'h27);
		`CHK(rd, {1'b0, v[9:3]})
		rdr(8'h28);
		`CHK(rd[2:0], v[2:0])
	endtask
	initial begin
		repeat (5) @(negedge ref_clk);
		resetn = 1'b1;
		rdr(8'h26);
		`CHK(rd, 8'h00)
		rdr(8'h30);
		`CHK(rd, 8'h00)
		$display("Test done: reset");
		foreach (rows[i]) begin
			wr(8'h26, {2'b10, rows[i].sel});
			rdr(8'h27);
			`CHK(rd[7], 1'b1)
			`CHK(mux_code, rows[i].sel)
			`CHK(prescale_en, rows[i].pre)
			`CHK(temp_sense_en, rows[i].tmp)
			// Raw codes only; scaling and temperature are software's job
			wait_res({rows[i].sel, 4'h5});
		end
		$display("Test done: channels");
		wr(8'h26, 8'h95);
		wr(8'h26, 8'h96);
		`CHK(mux_code, 6'h15)
		wait_res({6'h15, 4'h5});
		rdr(8'h26);
		`CHK(rd, 8'h16)
		wr(8'h26, 8'h17);
		repeat (300) @(negedge ref_clk);
		wait_res({6'h15, 4'h5});
		$display("Test done: refuse and hold");
		wr(8'h46, 8'h11);
		wr(8'h48, 8'h08);
		`CHK(audio_amp_en, 1'b1)
		for (n = 0; n < 2000 && led_valid !== 1'b1; n++) @(negedge ref_clk);
		`CHK(led_level, 8'h95)
		`CHK(lv_rgb_en, 3'b100)
		`CHK(hv_rgb_en, 3'b000)
		wr(8'h26, 8'h96);
		repeat (4380) @(negedge ref_clk);
		`CHK(led_valid, 1'b1)
		wr(8'h46, 8'h01);
		wr(8'h48, 8'h18);
		led_ready = 1'b1;
		repeat (300) @(negedge ref_clk);
		led_ready = 1'b0;
		for (n = 0; n < 2000 && led_valid !== 1'b1; n++) @(negedge ref_clk);
		`CHK(led_level, 8'hff)
		`CHK(lv_rgb_en, 3'b110)
		`CHK(hv_rgb_en, 3'b110)
		wr(8'h48, 8'h00);
		for (n = 0; n < 400 && conv_active !== 1'b0; n++) @(negedge ref_clk);
		wait_res({6'h15, 4'h5});
		$display("Test done: audio");
		wr(8'h26, 8'h8c);
		repeat (20) @(negedge ref_clk);
		resetn = 1'b0;
		repeat (5) @(negedge ref_clk);
		resetn = 1'b1;
		rdr(8'h26);
		`CHK(rd, 8'h00)
		`CHK(conv_active, 1'b0)
		$display("Test done: mid reset");
		close_out();
	end
endmodule // tb_sar_converter_sequencer
bind sar_converter_sequencer sar_converter_sequencer_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
	.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mux_code(mux_code),
	.prescale_en(prescale_en), .temp_sense_en(temp_sense_en), .sample_hold(sample_hold),
	.conv_active(conv_active), .audio_amp_en(audio_amp_en), .led_ready(led_ready),
	.led_valid(led_valid), .led_level(led_level));
`default_nettype wire
